//--- logic/ee_access_ctrl.sv
// What this block does
// - Six-bit linear address selects bytes 0 to 63.
// - Unused address and control bits read zero and ignore writes.
// - Data register feeds programming and receives read bytes.
// - Mode 00 atomic 3.4 ms, 01 erase, 10 write 1.8 ms, 11 reserved.
// - Mode writes ignored while programming is busy.
// - Reset clears mode to 00 unless programming is busy.
// - Ready interrupt raised when enabled, global enable set, idle.
// - Master enable self-clears after four cycles; strobe then programs.
// - Strobe without master enable does nothing.
// - No programming while flash self-programming is active.
// - Program strobe stays set while busy, hardware clears it.
// - Starting programming stalls the CPU two cycles.
// - Read strobe fetches byte at once and stalls CPU four cycles.
// - While busy, reads refused and address held.
// - Control layout mode 5:4, rie 3, master 2, prog 1, read 0.
// - Running programming completes through a reset.
//
// The implementer's own choice: register access over APB.
module ee_access_ctrl
	import ee_access_pkg::*;
#(
	parameter int ATOMIC_CYCLES = CYC_ATOMIC,
	parameter int SPLIT_CYCLES = CYC_SPLIT
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_global_irq_en,
	input wire logic i_flash_selfprog_flag,
	output logic o_ready_irq,
	output logic o_cpu_stall,
	output logic o_busy
);
	localparam int TW = 24;
	logic [ADDR_W-1:0] ee_address_field_ff;
	logic [DATA_W-1:0] ee_data_ff;
	logic [1:0] prog_mode_field_ff;
	logic ready_irq_enable_ff;
	logic master_write_enable_ff;
	logic read_strobe_ff;
	logic [2:0] master_cnt_ff;
	// Power-up idle; busy is never reset so programming completes
	logic busy_ff = 1'b0;
	logic [1:0] op_mode_ff;
	logic [ADDR_W-1:0] op_addr_ff;
	logic [DATA_W-1:0] op_data_ff;
	logic [2:0] stall_cnt_ff;
	logic [31:0] prdata_ff;
	logic refused_ff;
	logic wr;
	logic rd;
	logic ctl_wr;
	logic start_prog;
	logic start_read;
	logic done;
	logic [DATA_W-1:0] arr_rdata;
	logic [7:0] ctl_rd;
	logic [TW-1:0] op_cycles;
	array_req_t areq;

	typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_WRITE} phase_t;
	phase_t phase_ff;

	assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0];
	assign rd = i_psel && i_penable && !i_pwrite;
	assign ctl_wr = wr && i_paddr == ADDR_CONTROL;
	// Strobe only counts with master enable and no flash programming
	assign start_prog = ctl_wr && i_pwdata[CTL_PROG] && master_write_enable_ff
		&& !busy_ff && !i_flash_selfprog_flag
		&& prog_mode_field_ff != PM_RSVD;
	assign start_read = ctl_wr && i_pwdata[CTL_READ] && !busy_ff;

	// Reset deliberately skips busy and op state so programming completes
	always_ff @(posedge i_clk) begin
		if (start_prog) begin
			busy_ff <= 1'b1;
			op_mode_ff <= prog_mode_field_ff;
			op_addr_ff <= ee_address_field_ff;
			op_data_ff <= ee_data_ff;
		end else if (done) begin
			busy_ff <= 1'b0;
		end
	end
	always_comb begin
		case (prog_mode_field_ff)
			PM_ATOMIC: op_cycles = TW'(ATOMIC_CYCLES);
			PM_ERASE: op_cycles = TW'(SPLIT_CYCLES);
			PM_WRITE: op_cycles = TW'(SPLIT_CYCLES);
			default: op_cycles = TW'(SPLIT_CYCLES);
		endcase
	end

	ee_timer #(.W(TW)) u_timer (
		.i_clk(i_clk),
		.i_load(start_prog),
		.i_count(op_cycles),
		.o_done(done)
	);

	// Array commit at completion: erase gives FF, write ANDs bits in
	always_comb begin
		areq.we = done;
		areq.addr = op_addr_ff;
		case (op_mode_ff)
			PM_ATOMIC: areq.wdata = op_data_ff;
			PM_ERASE: areq.wdata = ERASED_BYTE;
			PM_WRITE: areq.wdata = op_data_ff & arr_rdata;
			default: areq.wdata = arr_rdata;
		endcase
	end

	ee_array u_array (
		.i_clk(i_clk),
		.i_req(areq),
		.i_raddr(busy_ff ? op_addr_ff : ee_address_field_ff),
		.o_rdata(arr_rdata)
	);

	always_ff @(posedge i_clk) begin
		if (wr && i_paddr == ADDR_ADDR_LOW && !busy_ff) begin
			ee_address_field_ff <= i_pwdata[ADDR_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (start_read) begin
			ee_data_ff <= arr_rdata;
		end else if (wr && i_paddr == ADDR_DATA) begin
			ee_data_ff <= i_pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst && !busy_ff) begin
			prog_mode_field_ff <= MODE_RESET;
		end else if (ctl_wr && !busy_ff && !start_prog) begin
			prog_mode_field_ff <= i_pwdata[CTL_MODE_LO+:2];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ready_irq_enable_ff <= 1'b0;
			read_strobe_ff <= 1'b0;
		end else begin
			if (ctl_wr) begin
				ready_irq_enable_ff <= i_pwdata[CTL_RIE];
			end
			// Read finishes at once, so the bit shows for one cycle only
			read_strobe_ff <= start_read;
		end
	end

	// Window counts four edges from the write that set the bit
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			master_write_enable_ff <= 1'b0;
			master_cnt_ff <= 3'h0;
		end else if (ctl_wr && i_pwdata[CTL_MASTER] && !i_pwdata[CTL_PROG]) begin
			master_write_enable_ff <= 1'b1;
			master_cnt_ff <= 3'(MASTER_WIN);
		end else if (start_prog || master_cnt_ff == 3'h1) begin
			master_write_enable_ff <= 1'b0;
			master_cnt_ff <= 3'h0;
		end else if (master_cnt_ff != 3'h0) begin
			master_cnt_ff <= master_cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			stall_cnt_ff <= 3'h0;
		end else if (start_prog) begin
			stall_cnt_ff <= 3'(STALL_PROG);
		end else if (start_read) begin
			stall_cnt_ff <= 3'(STALL_READ);
		end else if (stall_cnt_ff != 3'h0) begin
			stall_cnt_ff <= stall_cnt_ff - 3'h1;
		end
	end

	// Control readback, top bits zero
	assign ctl_rd = {2'h0, prog_mode_field_ff, ready_irq_enable_ff,
		master_write_enable_ff, busy_ff, read_strobe_ff};

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			prdata_ff <= 32'h0;
			refused_ff <= 1'b0;
		end else if (i_psel && !i_penable) begin
			refused_ff <= 1'b0;
			case (i_paddr)
				ADDR_CONTROL: prdata_ff <= {24'h0, ctl_rd};
				ADDR_DATA: prdata_ff <= {24'h0, ee_data_ff};
				ADDR_ADDR_LOW: prdata_ff <= {24'h0, zext6(ee_address_field_ff)};
				ADDR_ADDR_HIGH: prdata_ff <= 32'h0;
				ADDR_STATUS: prdata_ff <= {29'h0, i_flash_selfprog_flag,
					stall_cnt_ff != 3'h0, busy_ff};
				default: begin
					prdata_ff <= 32'h0;
					refused_ff <= 1'b1;
				end
			endcase
		end
	end

	// Access phase is always one cycle; read data latched at setup
	assign o_pready = i_psel && i_penable;
	assign o_pslverr = o_pready && refused_ff;
	assign o_prdata = prdata_ff;
	assign o_ready_irq = ready_irq_enable_ff && i_global_irq_en && !busy_ff;
	assign o_cpu_stall = stall_cnt_ff != 3'h0;
	assign o_busy = busy_ff;
	logic unused_rd;
	assign unused_rd = rd;
endmodule

//--- common/ee_access_pkg.sv
package ee_access_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h1F;
	localparam logic [7:0] IDX_ADDR_LOW = 8'h21;
	localparam logic [7:0] IDX_ADDR_HIGH = 8'h22;
	localparam logic [7:0] IDX_DATA = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h23;
	localparam logic [11:0] ADDR_CONTROL = 12'h07C;
	localparam logic [11:0] ADDR_DATA = 12'h080;
	localparam logic [11:0] ADDR_ADDR_LOW = 12'h084;
	localparam logic [11:0] ADDR_ADDR_HIGH = 12'h088;
	localparam logic [11:0] ADDR_STATUS = 12'h08C;
	// Control field positions
	localparam int CTL_READ = 0;
	localparam int CTL_PROG = 1;
	localparam int CTL_MASTER = 2;
	localparam int CTL_RIE = 3;
	localparam int CTL_MODE_LO = 4;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int EE_DEPTH = 64;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Timing
	localparam int CLK_HZ = 50000000;
	localparam int T_ATOMIC_US = 3400;
	localparam int T_SPLIT_US = 1800;
	localparam int CYC_ATOMIC = T_ATOMIC_US * (CLK_HZ / 1000000);
	localparam int CYC_SPLIT = T_SPLIT_US * (CLK_HZ / 1000000);
	localparam int MASTER_WIN = 4;
	localparam int STALL_PROG = 2;
	localparam int STALL_READ = 4;
	typedef enum logic [1:0] {
		PM_ATOMIC = 2'h0,
		PM_ERASE = 2'h1,
		PM_WRITE = 2'h2,
		PM_RSVD = 2'h3
	} prog_mode_t;
	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} array_req_t;
	function automatic logic [7:0] zext6(input logic [ADDR_W-1:0] v);
		return {2'h0, v};
	endfunction
endpackage

//--- logic/ee_array.sv
module ee_array
	import ee_access_pkg::*;
(
	input wire logic i_clk,
	input wire array_req_t i_req,
	input wire logic [ADDR_W-1:0] i_raddr,
	output logic [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] mem [EE_DEPTH];
	always_ff @(posedge i_clk) begin
		if (i_req.we) begin
			mem[i_req.addr] <= i_req.wdata;
		end
	end
	assign o_rdata = mem[i_raddr];
endmodule

//--- logic/ee_timer.sv
module ee_timer
	import ee_access_pkg::*;
#(
	parameter int W = 24
) (
	input wire logic i_clk,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_done
);
	logic [W-1:0] cnt_ff;
	// Power-up idle; a system reset must not stop a running count
	logic run_ff = 1'b0;
	// No reset: a running operation must finish across a system reset
	always_ff @(posedge i_clk) begin
		if (i_load) begin
			cnt_ff <= i_count;
			run_ff <= 1'b1;
		end else if (run_ff && cnt_ff <= W'(1)) begin
			run_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (run_ff) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end
	assign o_done = run_ff && cnt_ff <= W'(1);
endmodule

//--- tb/ee_flash_model.sv
module ee_flash_model #(
	parameter int HOLD = 30
) (
	input wire logic i_clk,
	input wire logic i_go,
	output logic o_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	// Flash write in progress holds the flag; EEPROM starts must wait
	always_ff @(posedge i_clk) begin
		n <= i_go ? HOLD : (n > 0 ? n - 1 : 0);
	end
	assign o_flag = n > 0;
endmodule

//--- tb/ee_access_ctrl_assertions.sv
module ee_access_ctrl_assertions
	import ee_access_pkg::*;
#(
	parameter int ATOMIC_CYCLES = CYC_ATOMIC,
	parameter int SPLIT_CYCLES = CYC_SPLIT
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_global_irq_en,
	input wire logic i_flash_selfprog_flag,
	input wire logic o_ready_irq,
	input wire logic o_cpu_stall,
	input wire logic o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic wr;
	logic rs;
	assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0];
	assign rs = i_psel && !i_penable && !i_pwrite;
	irq_idle_a: assert property (
		o_ready_irq |-> i_global_irq_en && !o_busy) else $error("irq bad");
	prog_stall_a: assert property (
		$rose(o_busy) |-> o_cpu_stall ##1 o_cpu_stall ##1 !o_cpu_stall)
		else $error("program stall length");
	read_stall_a: assert property (
		wr && i_paddr == ADDR_CONTROL && i_pwdata[1:0] == 2'h1 && !o_busy
		|=> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read stall");
	stall_cause_a: assert property (
		$rose(o_cpu_stall) |-> $past(wr)) else $error("stall uncaused");
	flash_block_a: assert property (
		i_flash_selfprog_flag && !o_busy |=> !o_busy) else $error("flash");
	busy_min_a: assert property (
		$rose(o_busy) |-> o_busy [*8]) else $error("busy too short");
	busy_read_a: assert property (
		rs && i_paddr == ADDR_CONTROL |=> o_prdata[CTL_PROG] == $past(o_busy)
		&& o_prdata[31:6] == 26'h0) else $error("control readback");
	high_zero_a: assert property (
		rs && i_paddr == ADDR_ADDR_HIGH |=> o_prdata == 32'h0)
		else $error("high address not zero");
endmodule
bind ee_access_ctrl ee_access_ctrl_assertions #(
	.ATOMIC_CYCLES(ATOMIC_CYCLES),
	.SPLIT_CYCLES(SPLIT_CYCLES)
) u_chk (.*);

//--- tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ee_access_pkg::*;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gie = 0, go = 0, er;
	logic [11:0] pa = 12'h0;
	logic [31:0] pwd = 32'h0, r, s = 32'h0000492E;
	logic [5:0] a;
	logic [7:0] d;
	logic [7:0] mem [64];
	wire logic [31:0] prd;
	wire logic rdy, perr, irq, stall, busy, flag;
	int errors = 0, tests_run = 0;
	// Short counts keep the run small; the checker follows the same values
	ee_access_ctrl #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) u_dut (
		.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hF),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(perr),
		.i_global_irq_en(gie), .i_flash_selfprog_flag(flag),
		.o_ready_irq(irq), .o_cpu_stall(stall), .o_busy(busy));
	ee_flash_model #(.HOLD(30)) u_flash (.i_clk(clk), .i_go(go), .o_flag(flag));
	initial forever #10 clk = ~clk;
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] expf(logic [1:0] m, logic [7:0] o, v);
		return m == 2'h0 ? v : m == 2'h1 ? 8'hFF : m == 2'h2 ? (o & v) : o;
	endfunction
	task automatic print_verdict();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, x);
		tests_run++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] v);
		int n = 0;
		psel <= 1;
		pwr <= w;
		pa <= ad;
		pwd <= {24'h0, v};
		@(posedge clk);
		pen <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (rdy !== 1'b1) begin
			errors++;
			print_verdict();
		end
		r = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] x);
		apb(0, ad, 8'h0);
		chk(r, x);
	endtask
	task automatic prog(input logic [5:0] ad, input logic [1:0] m, logic [7:0] v);
		apb(1, ADDR_ADDR_LOW, {2'h0, ad});
		apb(1, ADDR_DATA, v);
		apb(1, ADDR_CONTROL, {2'h0, m, 4'hC});
		apb(1, ADDR_CONTROL, {2'h0, m, 4'hA});
	endtask
	task automatic idle();
		int n = 0;
		@(posedge clk);
		while ((busy | flag) !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			errors++;
			print_verdict();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		rd(ADDR_CONTROL, 32'h0);
		rd(ADDR_ADDR_HIGH, 32'h0);
		apb(1, ADDR_ADDR_LOW, 8'hFF);
		rd(ADDR_ADDR_LOW, 32'h3F);
		apb(1, 12'h100, 8'h0);
		chk({31'h0, er}, 32'h1);
		// No handler runs here, so no sequence is ever cut
		gie <= 1;
		apb(1, ADDR_CONTROL, 8'hC8);
		rd(ADDR_CONTROL, 32'h08);
		chk({31'h0, irq}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			a = 6'(rnd());
			for (int m = 0; m < 4; m++) begin
				d = 8'(rnd());
				prog(a, 2'(m), d);
				if (m != 3) begin
					apb(1, ADDR_CONTROL, 8'h38);
					rd(ADDR_CONTROL, {26'h0, 2'(m), 4'hA});
					chk({31'h0, irq}, 32'h0);
					apb(1, ADDR_ADDR_LOW, {2'h0, ~a});
					rd(ADDR_ADDR_LOW, {26'h0, a});
				end else rd(ADDR_CONTROL, 32'h38);
				idle();
				mem[a] = expf(2'(m), mem[a], d);
				apb(1, ADDR_CONTROL, 8'h09);
				rd(ADDR_DATA, {24'h0, mem[a]});
			end
		end
		apb(1, ADDR_CONTROL, 8'h0C);
		repeat (3) @(posedge clk);
		apb(1, ADDR_CONTROL, 8'h0A);
		rd(ADDR_CONTROL, 32'h08);
		go <= 1;
		@(posedge clk);
		go <= 0;
		prog(a, 2'h0, ~mem[a]);
		rd(ADDR_CONTROL, 32'h08);
		idle();
		apb(1, ADDR_CONTROL, 8'h01);
		rd(ADDR_DATA, {24'h0, mem[a]});
		prog(a, 2'h1, 8'h0);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		rd(ADDR_CONTROL, 32'h12);
		idle();
		apb(1, ADDR_CONTROL, 8'h01);
		rd(ADDR_DATA, 32'hFF);
		print_verdict();
	end
endmodule
